// file: hdl/odc_regs.svh
// register offsets, field positions, reset values and counts of the block
`ifndef ODC_REGS_SVH
`define ODC_REGS_SVH
// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define ODC_OFF_MODE_ZERO  12'h000
`define ODC_OFF_MODE_ONE   12'h004
`define ODC_OFF_MODE_TWO   12'h008
`define ODC_OFF_LAT_CFG    12'h00C
`define ODC_OFF_STATUS     12'h010
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ODC_MR0_DLL_PD     12
`define ODC_MR1_NOM_A2     2
`define ODC_MR1_NOM_A6     6
`define ODC_MR1_NOM_A9     9
`define ODC_MR2_WR_A9      9
`define ODC_MR2_WR_A10     10
`define ODC_MR2_CWL_LO     3
`define ODC_MR2_CWL_HI     5
`define ODC_CFG_AL_LO      0
`define ODC_CFG_AL_HI      3
`define ODC_CFG_BURST_LO   4
`define ODC_CFG_BURST_HI   5
`define ODC_ST_TERM        0
`define ODC_ST_WRITE       1
`define ODC_ST_DYN         2
`define ODC_ST_SYNC        3
`define ODC_ST_EN          4
`define ODC_ST_LAT_LO      8
`define ODC_ST_LAT_HI      13
// ----------------------------------------------------------------------
// input bit order in the sampled vector
// ----------------------------------------------------------------------
`define ODC_IN_CK          0
`define ODC_IN_PIN         1
`define ODC_IN_WR          2
`define ODC_IN_CHOP        3
`define ODC_IN_SREF        4
`define ODC_IN_DLL         5
`define ODC_IN_PPD         6
`define ODC_IN_DRV         7
// ----------------------------------------------------------------------
// reset values and latency figures
// ----------------------------------------------------------------------
`define ODC_RST_MODE       16'h0000
`define ODC_RST_CFG        8'h00
`define ODC_CWL_BASE       6'h05
`define ODC_LAT_SUB        6'h02
`define ODC_HOLD_CHOP      3'h4
`define ODC_HOLD_FULL      3'h6
`endif

// file: hdl/odc_pkg.sv
// types shared by the termination control block
package odc_pkg;
  typedef logic [15:0] odc_mode_t;
  typedef logic [5:0]  odc_lane_t;
  typedef logic [7:0]  odc_in_t;
  typedef enum logic [1:0] {
    ODC_BURST_FULL = 2'b00,
    ODC_BURST_OTF  = 2'b01,
    ODC_BURST_CHOP = 2'b10
  } odc_burst_e;
endpackage

// file: hdl/odc_term_ctrl.sv
// on-die termination control with apb register access
//
// Behaviour
// - one pin switches termination of all lanes
// - nonzero nominal or write bits enable termination
// - pin ignored when disabled or self-refreshing
// - registered pin low off, high on
// - on/off from pin only, no commands
// - synchronous timing while loop on and locked
// - on/off a latency after pin sampled
// - latency is write cas plus additive minus two
// - termination back only when driving stops
// - either write bit enables dynamic switching
// - strength codes from mode registers one, two
// - no write: nominal strength, pin timing
// - write strength a latency after write
// - nominal again latency plus four or six
// - frozen loop power-down: pin applied undelayed
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "odc_regs.svh"
module odc_term_ctrl #(
  parameter int HIST_DEPTH = 32
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              cmd_clk,
  input  wire logic              termination_control_pin,
  input  wire logic              write_cmd,
  input  wire logic              write_chop,
  input  wire logic              self_refresh,
  input  wire logic              dll_locked,
  input  wire logic              precharge_pd,
  input  wire logic              read_driving,
  output odc_pkg::odc_lane_t     term_lane_en,
  output logic [2:0]             rtt_code,
  output logic                   rtt_write
);
  import odc_pkg::*;

  typedef struct packed {
    odc_in_t                s1;
    odc_in_t                s2;
    odc_in_t                s3;
    odc_in_t                filt;
    logic                   ck_q;
    odc_mode_t              mr0;
    odc_mode_t              mr1;
    odc_mode_t              mr2;
    logic [7:0]             cfg;
    logic [HIST_DEPTH-1:0]  hist_pin;
    logic [HIST_DEPTH-1:0]  hist_wr;
    logic [HIST_DEPTH-1:0]  hist_chop;
    logic [2:0]             wr_cnt;
    logic                   term_r;
    logic                   wr_str_r;
    odc_lane_t              lanes_r;
    logic [2:0]             rtt_r;
    logic                   rtt_wr_r;
    logic [31:0]            prdata_r;
  } odc_state_s;

  odc_state_s st_r;
  odc_state_s st_nxt;

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  function automatic logic [2:0] reg_sel(input logic [11:0] addr);
    case (addr)
      `ODC_OFF_MODE_ZERO: reg_sel = 3'h1;
      `ODC_OFF_MODE_ONE:  reg_sel = 3'h2;
      `ODC_OFF_MODE_TWO:  reg_sel = 3'h3;
      `ODC_OFF_LAT_CFG:   reg_sel = 3'h4;
      `ODC_OFF_STATUS:    reg_sel = 3'h5;
      default:            reg_sel = 3'h0;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // derived configuration
  // ----------------------------------------------------------------------
  logic [5:0]  write_cas_latency;
  logic [5:0]  lat;
  logic [4:0]  lat_idx;
  logic [2:0]  nom_code;
  logic [1:0]  wr_code;
  logic        dyn_en;
  logic        term_cfg_en;
  logic        sync_mode;
  logic        ck_rise;
  logic        gate_ok;
  odc_burst_e  burst_mode;

  // latency recomputed from live settings
  assign write_cas_latency = `ODC_CWL_BASE
             + {3'h0, st_r.mr2[`ODC_MR2_CWL_HI:`ODC_MR2_CWL_LO]};
  assign lat = write_cas_latency + {2'h0, st_r.cfg[`ODC_CFG_AL_HI:`ODC_CFG_AL_LO]}
             - `ODC_LAT_SUB;
  assign lat_idx = (lat > 6'(HIST_DEPTH)) ? 5'(HIST_DEPTH - 1)
                                          : 5'(lat - 6'h01);
  // strength codes and enables
  assign nom_code = {st_r.mr1[`ODC_MR1_NOM_A9], st_r.mr1[`ODC_MR1_NOM_A6],
                     st_r.mr1[`ODC_MR1_NOM_A2]};
  assign wr_code  = {st_r.mr2[`ODC_MR2_WR_A10],
                     st_r.mr2[`ODC_MR2_WR_A9]};
  assign dyn_en      = |wr_code;
  assign term_cfg_en = (|nom_code) | dyn_en;
  // frozen loop in precharge power-down leaves synchronous timing
  assign sync_mode = st_r.filt[`ODC_IN_DLL]
                   & ~(st_r.filt[`ODC_IN_PPD]
                       & ~st_r.mr0[`ODC_MR0_DLL_PD]);
  assign ck_rise = st_r.filt[`ODC_IN_CK] & ~st_r.ck_q;
  assign gate_ok = term_cfg_en & ~st_r.filt[`ODC_IN_SREF]
                 & ~st_r.filt[`ODC_IN_DRV];
  assign burst_mode = odc_burst_e'(
    st_r.cfg[`ODC_CFG_BURST_HI:`ODC_CFG_BURST_LO]);

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [2:0] sel;
    logic       chop;
    sel  = reg_sel(paddr);
    chop = 1'b0;
    st_nxt = st_r;
    // three-stage sampling, change taken once stages two and three agree
    st_nxt.s1   = {read_driving, precharge_pd, dll_locked, self_refresh,
                   write_chop, write_cmd, termination_control_pin, cmd_clk};
    st_nxt.s2   = st_r.s1;
    st_nxt.s3   = st_r.s2;
    st_nxt.filt = (st_r.s2 & st_r.s3) | (st_r.filt & (st_r.s2 ^ st_r.s3));
    st_nxt.ck_q = st_r.filt[`ODC_IN_CK];
    // burst length of a write, fixed or chosen with it
    unique case (burst_mode)
      ODC_BURST_FULL: chop = 1'b0;
      ODC_BURST_OTF:  chop = st_r.filt[`ODC_IN_CHOP];
      ODC_BURST_CHOP: chop = 1'b1;
      default:        chop = 1'b0;
    endcase
    // command clock edge: shift pin and write history
    if (ck_rise) begin
      st_nxt.hist_pin  = {st_r.hist_pin[HIST_DEPTH-2:0],
                          st_r.filt[`ODC_IN_PIN]};
      st_nxt.hist_wr   = {st_r.hist_wr[HIST_DEPTH-2:0],
                          st_r.filt[`ODC_IN_WR]};
      st_nxt.hist_chop = {st_r.hist_chop[HIST_DEPTH-2:0], chop};
      if (sync_mode) begin
        st_nxt.term_r = st_r.hist_pin[lat_idx];
      end
      // strength change from a write delayed by the same latency
      if (dyn_en && sync_mode && st_r.hist_wr[lat_idx]) begin
        st_nxt.wr_str_r = 1'b1;
        st_nxt.wr_cnt   = st_r.hist_chop[lat_idx] ? `ODC_HOLD_CHOP
                                                  : `ODC_HOLD_FULL;
      end else if (st_r.wr_cnt != 3'h0) begin
        st_nxt.wr_cnt = st_r.wr_cnt - 3'h1;
        if (st_r.wr_cnt == 3'h1) begin
          st_nxt.wr_str_r = 1'b0;
        end
      end
    end
    // undelayed pin while the loop is frozen
    if (!sync_mode) begin
      st_nxt.term_r   = st_r.filt[`ODC_IN_PIN];
      st_nxt.wr_str_r = 1'b0;
      st_nxt.wr_cnt   = 3'h0;
    end
    if (!dyn_en) begin
      st_nxt.wr_str_r = 1'b0;
      st_nxt.wr_cnt   = 3'h0;
    end
    // all lanes follow one gated termination state
    st_nxt.lanes_r  = {$bits(odc_lane_t){st_nxt.term_r & gate_ok}};
    st_nxt.rtt_wr_r = st_r.wr_str_r;
    st_nxt.rtt_r    = st_r.wr_str_r ? {1'b0, wr_code} : nom_code;
    // apb: read data caught in setup, writes in access
    if (psel && !penable) begin
      unique case (sel)
        3'h1:    st_nxt.prdata_r = {16'h0000, st_r.mr0};
        3'h2:    st_nxt.prdata_r = {16'h0000, st_r.mr1};
        3'h3:    st_nxt.prdata_r = {16'h0000, st_r.mr2};
        3'h4:    st_nxt.prdata_r = {24'h000000, st_r.cfg};
        3'h5: begin
          st_nxt.prdata_r = 32'h00000000;
          st_nxt.prdata_r[`ODC_ST_TERM]  = st_r.lanes_r[0];
          st_nxt.prdata_r[`ODC_ST_WRITE] = st_r.wr_str_r;
          st_nxt.prdata_r[`ODC_ST_DYN]   = dyn_en;
          st_nxt.prdata_r[`ODC_ST_SYNC]  = sync_mode;
          st_nxt.prdata_r[`ODC_ST_EN]    = term_cfg_en;
          st_nxt.prdata_r[`ODC_ST_LAT_HI:`ODC_ST_LAT_LO] = lat;
        end
        default: st_nxt.prdata_r = 32'h00000000;
      endcase
    end
    if (psel && penable && pwrite) begin
      unique case (sel)
        3'h1:    st_nxt.mr0 = pwdata[15:0];
        3'h2:    st_nxt.mr1 = pwdata[15:0];
        3'h3:    st_nxt.mr2 = pwdata[15:0];
        3'h4:    st_nxt.cfg = pwdata[7:0];
        default: st_nxt.cfg = st_r.cfg;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r     <= '0;
      st_r.mr0 <= `ODC_RST_MODE;
      st_r.mr1 <= `ODC_RST_MODE;
      st_r.mr2 <= `ODC_RST_MODE;
      st_r.cfg <= `ODC_RST_CFG;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs
  assign term_lane_en = st_r.lanes_r;
  assign rtt_code     = st_r.rtt_r;
  assign rtt_write    = st_r.rtt_wr_r;
  assign prdata       = st_r.prdata_r;
  assign pready       = 1'b1;
  assign pslverr      = psel & penable
                      & ((reg_sel(paddr) == 3'h0)
                         | (pwrite & (reg_sel(paddr) == 3'h5)));

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  property p_sref_off;
    @(posedge pclk) disable iff (!presetn)
    st_r.filt[`ODC_IN_SREF] |=> (term_lane_en == '0);
  endproperty
  a_sref_off: assert property (p_sref_off)
    else $error("termination on during self-refresh");

  property p_cfg_off;
    @(posedge pclk) disable iff (!presetn)
    !term_cfg_en |=> (term_lane_en == '0);
  endproperty
  a_cfg_off: assert property (p_cfg_off)
    else $error("termination on while disabled by mode bits");

  property p_drive_off;
    @(posedge pclk) disable iff (!presetn)
    st_r.filt[`ODC_IN_DRV] |=> (term_lane_en == '0);
  endproperty
  a_drive_off: assert property (p_drive_off)
    else $error("termination on while driving read data");

  property p_sync_on;
    @(posedge pclk) disable iff (!presetn)
    (ck_rise && sync_mode && st_r.hist_pin[lat_idx] && gate_ok)
      |=> (term_lane_en == '1);
  endproperty
  a_sync_on: assert property (p_sync_on)
    else $error("termination not on after turn-on latency");

  property p_sync_off;
    @(posedge pclk) disable iff (!presetn)
    (ck_rise && sync_mode && !st_r.hist_pin[lat_idx])
      |=> (term_lane_en == '0);
  endproperty
  a_sync_off: assert property (p_sync_off)
    else $error("termination not off after turn-off latency");

  property p_async_on;
    @(posedge pclk) disable iff (!presetn)
    (!sync_mode && st_r.filt[`ODC_IN_PIN] && gate_ok)
      |=> (term_lane_en == '1);
  endproperty
  a_async_on: assert property (p_async_on)
    else $error("undelayed termination not applied");

  property p_write_str;
    @(posedge pclk) disable iff (!presetn)
    (ck_rise && dyn_en && sync_mode && st_r.hist_wr[lat_idx])
      |=> ##1 rtt_write;
  endproperty
  a_write_str: assert property (p_write_str)
    else $error("write strength not selected after write");

  property p_nom_code;
    @(posedge pclk) disable iff (!presetn)
    !st_r.wr_str_r |=> (rtt_code == $past(nom_code)) && !rtt_write;
  endproperty
  a_nom_code: assert property (p_nom_code)
    else $error("nominal strength code wrong");

  property p_write_back;
    @(posedge pclk) disable iff (!presetn)
    (ck_rise && st_r.wr_cnt == 3'h1 && !st_r.hist_wr[lat_idx])
      |=> !st_r.wr_str_r;
  endproperty
  a_write_back: assert property (p_write_back)
    else $error("nominal strength not restored after write");

  property p_dyn_off;
    @(posedge pclk) disable iff (!presetn)
    !dyn_en |=> ##1 !rtt_write;
  endproperty
  a_dyn_off: assert property (p_dyn_off)
    else $error("write strength used with dynamic switching off");

endmodule
`default_nettype wire

// file: bench/odc_ctrl_model.sv
// controller model: command clock, termination pin and write commands
`timescale 1ns/10ps
`default_nettype none
module odc_ctrl_model (
  output logic cmd_clk,
  output logic termination_control_pin,
  output logic write_cmd,
  output logic write_chop
);
  event sampled;
  // ----------------------------------------------------------------
  // command clock, free running, phase unrelated to pclk
  // ----------------------------------------------------------------
  initial begin
    cmd_clk = 1'b0;
    termination_control_pin = 1'b0;
    write_cmd = 1'b0;
    write_chop = 1'b0;
    #7;
    forever #100 cmd_clk = ~cmd_clk;
  end
  // pin high for hi edges, at least four (six with a write), optional write with the first edge
  task automatic pulse(input int hi, input bit wr, input bit chop);
    int n;
    n = (hi < 4) ? 4 : hi;
    if (wr && n < 6) n = 6;
    @(negedge cmd_clk);
    termination_control_pin <= 1'b1;
    write_cmd <= wr;
    write_chop <= chop;
    @(posedge cmd_clk);
    -> sampled;
    @(negedge cmd_clk);
    write_cmd <= 1'b0;
    write_chop <= ~chop; // no write: chop is not held
    repeat (n - 1) @(posedge cmd_clk);
    @(negedge cmd_clk);
    termination_control_pin <= 1'b0;
    @(posedge cmd_clk);
  endtask
endmodule
`default_nettype wire

// file: bench/odc_term_ctrl_bench.sv
// testbench of the termination control block
`timescale 1ns/10ps
`default_nettype none
`include "odc_regs.svh"
module odc_term_ctrl_bench;
  import odc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        cmd_clk, pin, wr, chop, sref, dll, ppd, rdrv, err;
  odc_lane_t   lanes;
  logic [2:0]  code;
  logic        rtt_write;
  int          n_fail, total_checks;
  odc_ctrl_model i_ctrl (.cmd_clk(cmd_clk), .termination_control_pin(pin),
    .write_cmd(wr), .write_chop(chop));
  odc_term_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd_clk(cmd_clk),
    .termination_control_pin(pin), .write_cmd(wr), .write_chop(chop),
    .self_refresh(sref), .dll_locked(dll), .precharge_pd(ppd),
    .read_driving(rdrv), .term_lane_en(lanes), .rtt_code(code),
    .rtt_write(rtt_write));
  // ----------------------------------------------------------------
  // clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    #200000;
    n_fail++;
    stop_test();
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer, waits for pready; the watchdog bounds the wait
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // n command clock edges, then settle a few pclk
  task automatic at(input int n);
    repeat (n) @(posedge cmd_clk);
    repeat (7) @(negedge pclk);
  endtask
  // write with pin high at latency 5, burst mode bm, write strength held b command clocks
  task automatic dyn(input logic [1:0] bm, input bit c, input int b);
    apb(1'b1, `ODC_OFF_LAT_CFG, {26'h0, bm, 4'h2});
    fork
      i_ctrl.pulse(8, 1'b1, c);
      begin
        @(i_ctrl.sampled);
        at(4);
        chk("lanes early", 32'(lanes), 32'h0);
        at(1);
        chk("lanes on", 32'(lanes), 32'h3F);
        chk("write strength", 32'(rtt_write), 32'h1);
        chk("write code", 32'(code), 32'h2);
        at(b - 1);
        chk("write held", 32'(rtt_write), 32'h1);
        at(1);
        chk("write end", 32'(rtt_write), 32'h0);
        chk("nominal code", 32'(code), 32'h1);
        at(7 - b);
        chk("lanes late", 32'(lanes), 32'h3F);
        at(1);
        chk("lanes off", 32'(lanes), 32'h0);
      end
    join
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, sref, ppd, rdrv} = 7'h00;
    dll = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and refused accesses
    apb(1'b0, `ODC_OFF_MODE_ONE, 32'h0);
    chk("mode one reset", rd, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped error", 32'(err), 32'h1);
    apb(1'b1, `ODC_OFF_STATUS, 32'hFFFF);
    chk("status write error", 32'(err), 32'h1);
    // all strength bits zero: pin has no effect
    fork
      i_ctrl.pulse(4, 1'b0, 1'b0);
      begin
        @(i_ctrl.sampled);
        at(6);
        chk("disabled lanes", 32'(lanes), 32'h0);
      end
    join
    // enable nominal and write strength, latency 5+2-2
    apb(1'b1, `ODC_OFF_MODE_ONE, 32'h4);
    apb(1'b1, `ODC_OFF_MODE_TWO, 32'h400);
    apb(1'b1, `ODC_OFF_LAT_CFG, 32'h2);
    apb(1'b0, `ODC_OFF_STATUS, 32'h0);
    chk("latency", 32'(rd[13:8]), 32'h5);
    chk("dynamic", 32'(rd[2]), 32'h1);
    dyn(2'h0, 1'b0, 6);
    dyn(2'h1, 1'b1, 4);
    dyn(2'h1, 1'b0, 6);
    dyn(2'h2, 1'b0, 4);
    // a read that ends late holds termination off; self-refresh forces off
    fork
      i_ctrl.pulse(10, 1'b0, 1'b0);
      begin
        @(i_ctrl.sampled);
        @(posedge pclk);
        // read planned to end before turn-on, runs late past it
        rdrv <= 1'b1;
        at(5);
        chk("read driving", 32'(lanes), 32'h0);
        @(posedge pclk);
        rdrv <= 1'b0;
        repeat (8) @(negedge pclk);
        chk("after read", 32'(lanes), 32'h3F);
        @(posedge pclk);
        sref <= 1'b1;
        repeat (8) @(negedge pclk);
        chk("self refresh", 32'(lanes), 32'h0);
        @(posedge pclk);
        sref <= 1'b0;
        repeat (8) @(negedge pclk);
        chk("on after", 32'(lanes), 32'h3F);
      end
    join
    // reprogrammed additive latency
    apb(1'b1, `ODC_OFF_LAT_CFG, 32'h4);
    apb(1'b0, `ODC_OFF_STATUS, 32'h0);
    chk("new latency", 32'(rd[13:8]), 32'h7);
    // frozen loop power-down: pin applied without latency
    at(8); // old pin history runs out first
    @(posedge pclk);
    ppd <= 1'b1;
    fork
      i_ctrl.pulse(4, 1'b0, 1'b0);
      begin
        @(i_ctrl.sampled);
        at(0);
        chk("async on", 32'(lanes), 32'h3F);
      end
    join
    at(0);
    chk("async off", 32'(lanes), 32'h0);
    // loop off: pin held low, write strength cleared
    @(posedge pclk);
    dll <= 1'b0;
    apb(1'b1, `ODC_OFF_MODE_TWO, 32'h0);
    apb(1'b0, `ODC_OFF_STATUS, 32'h0);
    chk("loop off status", 32'(rd[4:0]), 32'h10);
    // loop on and kept on in precharge power-down: synchronous
    @(posedge pclk);
    dll <= 1'b1;
    apb(1'b1, `ODC_OFF_MODE_ZERO, 32'h1000);
    apb(1'b0, `ODC_OFF_STATUS, 32'h0);
    chk("kept loop sync", 32'(rd[3]), 32'h1);
    stop_test();
  end
endmodule
`default_nettype wire
